// ---- hdl/cpu_reset_sequencer.sv ----
// reset sequencer for the 16-bit core: init sequence, straps, reset exception
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ns

module cpu_reset_sequencer #(
  parameter int unsigned SEQ_LEN  = rst_seq_pkg::SEQ_CYCLES,        // init sequence cycles
  parameter int unsigned WDOG_LEN = rst_seq_pkg::WDOG_RESET_CYCLES  // watchdog reset cycles
) (
  input  wire logic        clk_sys_in,              // system clock, 100 MHz
  input  wire logic        rst_n_in,                // synchronous reset, active low
  input  wire logic        clk_en_in,               // clock enable, freezes state when low
  input  wire logic        ext_reset_n_in,          // async reset pin, active low
  input  wire logic        code_memory_select_in,   // strap: low = external code memory
  input  wire logic        bus_width_strap_in,      // strap: low = 8-bit, high = 16-bit
  input  wire logic        reset_instr_in,          // pulse: reset instruction executed
  input  wire logic        wdog_overflow_in,        // pulse: watchdog overflow
  input  wire logic        bus_cfg_wr_in,           // pulse: software write to bus config
  input  wire logic        bus_cfg_width_in,        // written bus width, 1 = 16-bit
  input  wire logic        vec_ack_in,              // vector word fetch done
  input  wire logic [15:0] vec_data_in,             // vector word read data
  output logic             core_reset_out,          // core held in reset / quiescent
  output logic             init_active_out,         // internal init sequence running
  output logic             seq_done_out,            // init sequence complete
  output logic             clear_regs_out,          // strobe: clear core state
  output logic [15:0]      code_segment_out,        // code segment
  output logic [15:0]      data_segment_reg_out,    // data segment
  output logic [15:0]      extra_segment_reg_out,   // extra segment
  output logic             seg_select_out,          // segment select control
  output logic [15:0]      user_stack_pointer_out,  // user stack pointer reset value
  output logic [15:0]      system_stack_pointer_out,// system stack pointer reset value
  output logic             page_zero_mode_out,      // config: page zero addressing
  output logic             compat_mode_out,         // config: compatibility mode
  output logic             interrupt_enable_out,    // global interrupt enable
  output logic             port_quasi_in_out,       // ports in quasi-bidirectional input
  output logic [7:0]       port_latch_out,          // port latch reset value
  output logic             sfr_clear_out,           // strobe: clear core SFRs
  output logic             trace_abort_out,         // abort pending trace exception
  output logic             ext_code_mem_out,        // 1 = external program memory
  output logic             bus_16bit_out,           // 1 = 16-bit external bus
  output logic             vec_req_out,             // vector word fetch request
  output logic [23:0]      vec_addr_out,            // vector word address
  output logic [15:0]      program_status_word_out, // status word from vector
  output logic [23:0]      start_addr_out,          // start address from vector
  output logic             start_valid_out,         // pulse: begin execution
  output logic             stack_push_out           // stack frame push request
);
  import rst_seq_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  // a synchronised level is believed only once flops 2 and 3 agree;
  // until then the level accepted last stands, so a one-clock glitch
  // on a pin never reaches the sequencer. the cost is one extra clock
  // of latency on every pin change, which the sequence can afford.
  function automatic logic agreed_level
  (
    input logic [2:0] sync,  // shift register, bit 2 oldest
    input logic       last   // level accepted so far
  );
    logic result;
    result = last;
    if (sync[1] == sync[2])
    begin
      result = sync[2];
    end
    return result;
  endfunction : agreed_level

  // ************************************************************
  // reset pin synchroniser
  // ************************************************************
  // flops reset to ones: after the bench reset the pin is taken as
  // released until the synchroniser has seen otherwise
  logic [2:0] pin_sync_q;
  logic [2:0] pin_sync_d;
  logic       pin_low_q;
  logic       pin_low_d;

  always_comb
  begin
    pin_sync_d = {pin_sync_q[1:0], ext_reset_n_in};
    // the pin counts as low only once flops 2 and 3 both see it low
    pin_low_d  = ~agreed_level(pin_sync_q, ~pin_low_q);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      pin_sync_q <= 3'b111;
      pin_low_q  <= 1'b0;
    end
    else if (clk_en_in)
    begin
      pin_sync_q <= pin_sync_d;
      pin_low_q  <= pin_low_d;
    end
  end

  // ************************************************************
  // strap synchronisers
  // ************************************************************
  // straps are filtered like the pin, so a strap that is still
  // settling when reset goes away does not leak into the choice.
  // they reset to ones, the level of the weak pull-ups.
  logic [2:0] cms_sync_q;
  logic [2:0] cms_sync_d;
  logic [2:0] bw_sync_q;
  logic [2:0] bw_sync_d;
  logic       cms_q;
  logic       cms_d;
  logic       bw_q;
  logic       bw_d;

  always_comb
  begin
    cms_sync_d = {cms_sync_q[1:0], code_memory_select_in};
    bw_sync_d  = {bw_sync_q[1:0], bus_width_strap_in};
    cms_d      = agreed_level(cms_sync_q, cms_q);
    bw_d       = agreed_level(bw_sync_q, bw_q);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      cms_sync_q <= 3'b111;
      bw_sync_q  <= 3'b111;
      cms_q      <= 1'b1;
      bw_q       <= 1'b1;
    end
    else if (clk_en_in)
    begin
      cms_sync_q <= cms_sync_d;
      bw_sync_q  <= bw_sync_d;
      cms_q      <= cms_d;
      bw_q       <= bw_d;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  // init always runs its full length, even when the pin is released
  // early, so every reset source leaves the core in the same cleared
  // state. quiet then waits for the filtered pin; the straps are
  // latched on the quiet to fetch edge, the release edge as seen
  // through the synchroniser.
  // limitation: the length is counted in clocks, so SEQ_LEN must be
  // rescaled whenever the system clock frequency changes.
  seq_state_t       state_q;
  seq_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] wdog_cnt_q;
  logic [CNT_W-1:0] wdog_cnt_d;
  logic             ext_mem_q;
  logic             ext_mem_d;
  logic             bus16_q;
  logic             bus16_d;
  logic [15:0]      psw_q;
  logic [15:0]      psw_d;
  logic [23:0]      start_q;
  logic [23:0]      start_d;
  logic             start_pulse_q;
  logic             start_pulse_d;
  logic             hold_reset;
  logic             soft_reset;

  // instruction and watchdog resets behave as if the pin were held
  assign soft_reset = reset_instr_in | wdog_overflow_in;
  assign hold_reset = pin_low_q | (wdog_cnt_q != '0);
  // the watchdog hold counter may outlive init; the core then waits in
  // quiet exactly as it would for a pin that is still held low

  always_comb
  begin
    state_d       = state_q;
    cnt_d         = cnt_q;
    wdog_cnt_d    = wdog_cnt_q;
    ext_mem_d     = ext_mem_q;
    bus16_d       = bus16_q;
    psw_d         = psw_q;
    start_d       = start_q;
    start_pulse_d = 1'b0;
    if (wdog_cnt_q != '0)
    begin
      wdog_cnt_d = wdog_cnt_q - 1'b1;
    end
    if (soft_reset)
    begin
      wdog_cnt_d = CNT_W'(WDOG_LEN);
    end
    if (bus_cfg_wr_in && state_q == ST_RUN)
    begin
      bus16_d = bus_cfg_width_in;
    end
    if (hold_reset || soft_reset)
    begin
      if (state_q == ST_RUN || state_q == ST_FETCH_PSW || state_q == ST_FETCH_START)
      begin
        state_d = ST_INIT;
        cnt_d   = '0;
      end
      else if (state_q == ST_INIT)
      begin
        if (cnt_q >= CNT_W'(SEQ_LEN - 1))
        begin
          state_d = ST_QUIET;
        end
        else
        begin
          cnt_d = cnt_q + 1'b1;
        end
      end
    end
    else
    begin
      case (state_q)
        ST_INIT:
        begin
          // released before the sequence finished: finish it first
          if (cnt_q >= CNT_W'(SEQ_LEN - 1))
          begin
            state_d = ST_QUIET;
          end
          else
          begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        ST_QUIET:
        begin
          // release edge: straps captured once; code memory held until next release, bus width also rewritten by bus config writes in run
          ext_mem_d = ~cms_q;
          bus16_d   = bw_q;
          state_d   = ST_FETCH_PSW;
        end
        ST_FETCH_PSW:
        begin
          if (vec_ack_in)
          begin
            psw_d   = vec_data_in;
            state_d = ST_FETCH_START;
          end
        end
        ST_FETCH_START:
        begin
          if (vec_ack_in)
          begin
            start_d       = {8'h00, vec_data_in};
            start_pulse_d = 1'b1;
            state_d       = ST_RUN;
          end
        end
        ST_RUN:
        begin
          // only a reset source leaves run; that path is handled above
          state_d = ST_RUN;
        end
        default:
        begin
          state_d = ST_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      state_q       <= ST_INIT;
      cnt_q         <= '0;
      wdog_cnt_q    <= '0;
      ext_mem_q     <= 1'b0;
      bus16_q       <= 1'b1;
      psw_q         <= 16'h0000;
      start_q       <= 24'h00_0000;
      start_pulse_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state_q       <= state_d;
      cnt_q         <= cnt_d;
      wdog_cnt_q    <= wdog_cnt_d;
      ext_mem_q     <= ext_mem_d;
      bus16_q       <= bus16_d;
      psw_q         <= psw_d;
      start_q       <= start_d;
      start_pulse_q <= start_pulse_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  logic in_init;
  assign in_init = (state_q == ST_INIT);

  assign core_reset_out           = (state_q == ST_INIT) || (state_q == ST_QUIET);
  assign init_active_out          = in_init;
  assign seq_done_out             = (state_q == ST_QUIET);

  // ************************************************************
  // reset values
  // ************************************************************
  // the values are constants; the core loads them while the clear
  // strobes stand, which keeps this block free of wide registers
  // only state registers are cleared; data RAM gets no write strobe at all
  assign clear_regs_out           = in_init;
  assign sfr_clear_out            = in_init;
  assign code_segment_out         = SEG_RESET_VAL;
  assign data_segment_reg_out     = SEG_RESET_VAL;
  assign extra_segment_reg_out    = SEG_RESET_VAL;
  assign seg_select_out           = 1'b0;
  assign user_stack_pointer_out   = STACK_RESET_VAL;
  assign system_stack_pointer_out = STACK_RESET_VAL;
  assign page_zero_mode_out       = 1'b0;
  assign compat_mode_out          = 1'b0;
  assign interrupt_enable_out     = 1'b0;
  assign port_quasi_in_out        = core_reset_out;
  assign port_latch_out           = PORT_LATCH_RESET;
  assign trace_abort_out          = core_reset_out;

  // ************************************************************
  // strap results
  // ************************************************************
  // no check against the fitted memory is made: a wrong strap shows
  // up only as a failing fetch in the core
  assign ext_code_mem_out         = ext_mem_q;
  assign bus_16bit_out            = bus16_q;

  // ************************************************************
  // reset exception vector fetch
  // ************************************************************
  // request stays up until acknowledged; the address moves to the
  // second word only after the status word has been taken
  assign vec_req_out              = (state_q == ST_FETCH_PSW) || (state_q == ST_FETCH_START);
  assign vec_addr_out             = RESET_VECTOR_ADDR +
                                    ((state_q == ST_FETCH_START) ? START_WORD_OFFSET
                                                                 : PSW_WORD_OFFSET);
  assign program_status_word_out  = psw_q;
  assign start_addr_out           = start_q;
  assign start_valid_out          = start_pulse_q;
  assign stack_push_out           = 1'b0;

endmodule : cpu_reset_sequencer

// ---- hdl/rst_seq_pkg.sv ----
// constants for the core reset sequencer
package rst_seq_pkg;

  localparam int unsigned CLK_FREQ_MHZ       = 100;
  // internal sequence: at least 10 us or 10 clocks, whichever is greater
  localparam int unsigned SEQ_MIN_TIME_US    = 10;
  localparam int unsigned SEQ_MIN_CLOCKS     = 10;
  localparam int unsigned SEQ_TIME_CYCLES    = SEQ_MIN_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned SEQ_CYCLES         = (SEQ_TIME_CYCLES > SEQ_MIN_CLOCKS) ?
                                               SEQ_TIME_CYCLES : SEQ_MIN_CLOCKS;
  // watchdog-driven internal reset length (implementation defined)
  localparam int unsigned WDOG_RESET_CYCLES  = 16;
  localparam int unsigned CNT_W              = 12;

  localparam logic [15:0] SEG_RESET_VAL      = 16'h0000;
  localparam logic [15:0] STACK_RESET_VAL    = 16'h0100;
  localparam logic [15:0] REG_RESET_VAL      = 16'h0000;
  localparam logic [7:0]  SFR_RESET_VAL      = 8'h00;
  localparam logic [7:0]  PORT_LATCH_RESET   = 8'hFF;
  localparam logic [23:0] RESET_VECTOR_ADDR  = 24'h00_0000;
  localparam logic [23:0] PSW_WORD_OFFSET    = 24'h00_0000;
  localparam logic [23:0] START_WORD_OFFSET  = 24'h00_0002;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_QUIET,
    ST_FETCH_PSW,
    ST_FETCH_START,
    ST_RUN
  } seq_state_t;

endpackage : rst_seq_pkg

// ---- verif/cpu_reset_sequencer_asserts.sv ----
// port assertions for the core reset sequencer
`timescale 1ns/1ns
// ****************************************
// checker
// ****************************************
module rst_seq_checker #(
  parameter int unsigned SEQ_LEN  = 1000,  // init sequence cycles
  parameter int unsigned WDOG_LEN = 16   // watchdog hold cycles
) (
  input wire logic        clk_sys_in, rst_n_in, wdog_overflow_in, bus_cfg_wr_in,  // controls
  input wire logic        bus_cfg_width_in, vec_ack_in, code_memory_select_in,  // inputs
  input wire logic        bus_width_strap_in, ext_reset_n_in, core_reset_out,  // pins
  input wire logic        init_active_out, seq_done_out, clear_regs_out, sfr_clear_out,  // seq
  input wire logic        seg_select_out, page_zero_mode_out, compat_mode_out,  // config
  input wire logic        interrupt_enable_out, port_quasi_in_out, trace_abort_out,  // misc
  input wire logic        ext_code_mem_out, bus_16bit_out, vec_req_out, start_valid_out,  // run
  input wire logic        stack_push_out,  // stack frame
  input wire logic [15:0] code_segment_out, data_segment_reg_out, extra_segment_reg_out,  // seg
  input wire logic [15:0] user_stack_pointer_out, system_stack_pointer_out,  // stacks
  input wire logic [7:0]  port_latch_out,  // port latch
  input wire logic [23:0] vec_addr_out  // vector address
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  // init cycles counted only after reset release, so the reset itself never stretches it
  // wide enough for the default sequence length of 1000 cycles
  logic [11:0] run_q;
  logic [11:0] run_d;
  always_comb run_d = (rst_n_in && init_active_out) ? run_q + 12'h001 : 12'h000;
  always_ff @(posedge clk_sys_in) run_q <= run_d;
  property p_seg;
    core_reset_out |-> code_segment_out == 16'h0000 && data_segment_reg_out == 16'h0000
      && extra_segment_reg_out == 16'h0000 && !seg_select_out;
  endproperty
  a_seg: assert property (p_seg) else $error("segment reset value wrong");
  property p_stack;
    (core_reset_out || vec_req_out) |-> user_stack_pointer_out == 16'h0100
      && system_stack_pointer_out == 16'h0100 && !stack_push_out;
  endproperty
  a_stack: assert property (p_stack) else $error("stack reset wrong");
  property p_cfg;
    core_reset_out |-> !page_zero_mode_out && !compat_mode_out && !interrupt_enable_out
      && port_quasi_in_out && trace_abort_out && port_latch_out == 8'hFF;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config reset wrong");
  property p_clear;
    init_active_out |-> clear_regs_out && sfr_clear_out && core_reset_out;
  endproperty
  a_clear: assert property (p_clear) else $error("clear strobes missing");
  property p_len;
    $fell(init_active_out) |-> run_q >= SEQ_LEN && seq_done_out;
  endproperty
  a_len: assert property (p_len) else $error("init sequence too short");
  property p_quiet;
    seq_done_out |-> core_reset_out && !init_active_out && !vec_req_out && !start_valid_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("activity while quiescent");
  property p_pin;
    $fell(ext_reset_n_in) && !core_reset_out ##1 !ext_reset_n_in [*5]
      |-> core_reset_out && !$past(core_reset_out, 4);
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset timing wrong");
  property p_wdog;
    wdog_overflow_in && !core_reset_out |=> core_reset_out [*8] ##1 core_reset_out [*8];
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset too short");
  property p_strap;
    $rose(vec_req_out) |-> ext_code_mem_out == !code_memory_select_in && $past(seq_done_out)
      && bus_16bit_out == bus_width_strap_in && vec_addr_out == 24'h00_0000;
  endproperty
  a_strap: assert property (p_strap) else $error("strap sample wrong");
  property p_hold;
    !core_reset_out && !$past(core_reset_out) |-> $stable(ext_code_mem_out);
  endproperty
  a_hold: assert property (p_hold) else $error("code memory choice moved");
  property p_bcfg;
    bus_cfg_wr_in && !core_reset_out && !vec_req_out |=> bus_16bit_out == $past(bus_cfg_width_in);
  endproperty
  a_bcfg: assert property (p_bcfg) else $error("bus width write lost");
  property p_vec;
    vec_req_out && vec_ack_in && vec_addr_out == 24'h00_0000
      |=> vec_req_out && vec_addr_out == 24'h00_0002;
  endproperty
  a_vec: assert property (p_vec) else $error("second vector word missing");
  property p_go;
    vec_req_out && vec_ack_in && vec_addr_out == 24'h00_0002 |=> start_valid_out && !vec_req_out;
  endproperty
  a_go: assert property (p_go) else $error("start not launched");
endmodule : rst_seq_checker

bind cpu_reset_sequencer rst_seq_checker #(.SEQ_LEN(SEQ_LEN), .WDOG_LEN(WDOG_LEN))
  rst_seq_checker_inst (.*);

// ---- verif/reset_circuit_model.sv ----
// model of the reset circuit, strap pins and reset vector memory
`timescale 1ns/1ns
// ****************************************
// far side model
// ****************************************
module reset_circuit_model #(
  parameter int unsigned PWR_LEN    = 40,        // scaled power-up hold
  parameter int unsigned RST_LEN    = 30,        // pin pulse length
  parameter logic [15:0] STATUS_WORD = 16'h8F00, // word at vector 0
  parameter logic [15:0] START_WORD  = 16'h0120  // word at vector 2
) (
  input  wire logic        clk_sys_in,             // system clock
  input  wire logic        pulse_in,               // start a pin reset
  input  wire logic        mem_sel_in,             // code memory strap level
  input  wire logic        bw_in,                  // bus width strap level
  input  wire logic        bw_float_in,            // strap left open
  input  wire logic [3:0]  lat_in,                 // vector answer delay
  input  wire logic        vec_req_in,             // vector fetch request
  input  wire logic [23:0] vec_addr_in,            // vector address
  output logic             ext_reset_n_out,        // reset pin
  output logic             code_memory_select_out, // strap pin
  output logic             bus_width_strap_out,    // strap pin
  output logic             vec_ack_out,            // vector word ready
  output logic [15:0]      vec_data_out            // vector word
);
  logic [7:0]  hold_q = 8'(PWR_LEN);
  logic [3:0]  wait_q = 4'h0;
  logic [15:0] word_q = 16'h0000;
  logic        ack_q  = 1'b0;
  logic        go;
  assign go = vec_req_in && !ack_q && wait_q == lat_in;
  always @(posedge clk_sys_in)
  begin
    hold_q <= pulse_in ? 8'(RST_LEN) : (hold_q != 8'h00) ? hold_q - 8'h01 : 8'h00;
    wait_q <= (vec_req_in && !go && !ack_q) ? wait_q + 4'h1 : 4'h0;
    ack_q <= go;
    if (go)
      word_q <= (vec_addr_in == 24'h00_0000) ? STATUS_WORD : START_WORD;
  end
  assign ext_reset_n_out = (hold_q == 8'h00);
  assign code_memory_select_out = mem_sel_in;
  assign bus_width_strap_out = bw_in | bw_float_in;  // weak pull-up when open
  assign vec_ack_out = ack_q;
  // data off the ack cycle is scrambled so a late capture cannot pass
  assign vec_data_out = ack_q ? word_q : ~word_q;
endmodule : reset_circuit_model

// ---- verif/tb_top.sv ----
// self-checking bench for the core reset sequencer
`timescale 1ns/1ns
// ****************************************
// bench
// ****************************************
module tb_top;
  localparam logic [15:0] STATUS_WORD = 16'h8F00;
  localparam logic [15:0] START_WORD  = 16'h0120;
  logic             clk_sys_in = 1'b0;
  logic             rst_n_in = 1'b0;
  logic             reset_instr = 1'b0, wdog = 1'b0, cfg_wr = 1'b0, cfg_w = 1'b0;
  logic             pulse = 1'b0, mem_sel = 1'b0, bw = 1'b0, bwf = 1'b1;
  logic [3:0]       lat = 4'h0;
  wire logic        pin_n, sel_w, bw_w, ack, vreq, core_rst, done, ext_mem, bus16, go;
  wire logic [15:0] vdata, status_w;
  wire logic [23:0] vaddr, start;
  int               miscompares = 0;
  int               samples_checked = 0;
  cpu_reset_sequencer #(.SEQ_LEN(12), .WDOG_LEN(16)) cpu_reset_sequencer_inst (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
    .ext_reset_n_in(pin_n), .code_memory_select_in(sel_w), .bus_width_strap_in(bw_w),
    .reset_instr_in(reset_instr), .wdog_overflow_in(wdog), .bus_cfg_wr_in(cfg_wr),
    .bus_cfg_width_in(cfg_w), .vec_ack_in(ack), .vec_data_in(vdata),
    .core_reset_out(core_rst), .init_active_out(), .seq_done_out(done),
    .clear_regs_out(), .code_segment_out(), .data_segment_reg_out(),
    .extra_segment_reg_out(), .seg_select_out(), .user_stack_pointer_out(),
    .system_stack_pointer_out(), .page_zero_mode_out(), .compat_mode_out(),
    .interrupt_enable_out(), .port_quasi_in_out(), .port_latch_out(), .sfr_clear_out(),
    .trace_abort_out(), .ext_code_mem_out(ext_mem), .bus_16bit_out(bus16),
    .vec_req_out(vreq), .vec_addr_out(vaddr), .program_status_word_out(status_w),
    .start_addr_out(start), .start_valid_out(go), .stack_push_out()
  );
  reset_circuit_model #(.STATUS_WORD(STATUS_WORD), .START_WORD(START_WORD))
    reset_circuit_model_inst (
    .clk_sys_in(clk_sys_in), .pulse_in(pulse), .mem_sel_in(mem_sel), .bw_in(bw),
    .bw_float_in(bwf), .lat_in(lat), .vec_req_in(vreq), .vec_addr_in(vaddr),
    .ext_reset_n_out(pin_n), .code_memory_select_out(sel_w), .bus_width_strap_out(bw_w),
    .vec_ack_out(ack), .vec_data_out(vdata)
  );
  initial
  begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic wait_start(input logic e, input logic b);
    int n;
    n = 0;
    while (go !== 1'b1 && n < 300)
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    chk("start_valid", go, 1'b1);
    chk("status", status_w, STATUS_WORD);
    chk("start", start, {8'h00, START_WORD});
    chk("code_mem", ext_mem, e);
    chk("bus_width", bus16, b);
    chk("running", core_rst, 1'b0);
  endtask : wait_start
  task automatic pin_reset(input logic c, input logic b, input logic [3:0] l);
    @(posedge clk_sys_in);
    mem_sel <= c;
    bw <= b;
    bwf <= 1'b0;
    lat <= l;
    pulse <= 1'b1;
    @(posedge clk_sys_in);
    pulse <= 1'b0;
    repeat (26) @(posedge clk_sys_in);
    #1;
    chk("quiet", {core_rst, done, go}, 3'b110);
    wait_start(!c, b);
  endtask : pin_reset
  task automatic soft_reset(input logic w, input logic e, input logic b);
    @(posedge clk_sys_in);
    reset_instr <= !w;
    wdog <= w;
    @(posedge clk_sys_in);
    reset_instr <= 1'b0;
    wdog <= 1'b0;
    #1;
    chk("soft_reset", core_rst, 1'b1);
    repeat (10) @(posedge clk_sys_in);
    #1;
    chk("soft_hold", core_rst, 1'b1);
    wait_start(e, b);
  endtask : soft_reset
  task automatic strap_hold();
    @(posedge clk_sys_in);
    mem_sel <= !mem_sel;
    repeat (8) @(posedge clk_sys_in);
    #1;
    chk("code_mem_hold", ext_mem, mem_sel);
  endtask : strap_hold
  task automatic bus_cfg(input logic w);
    @(posedge clk_sys_in);
    cfg_wr <= 1'b1;
    cfg_w <= w;
    @(posedge clk_sys_in);
    cfg_wr <= 1'b0;
    #1;
    chk("bus_cfg", bus16, w);
  endtask : bus_cfg
  initial
  begin
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    wait_start(1'b1, 1'b1);
    bus_cfg(1'b0);
    bus_cfg(1'b1);
    pin_reset(1'b1, 1'b0, 4'h3);
    strap_hold();
    pin_reset(1'b0, 1'b1, 4'h0);
    soft_reset(1'b0, 1'b1, 1'b1);
    soft_reset(1'b1, 1'b1, 1'b1);
    close_out();
  end
  // the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys_in);
    miscompares++;
    close_out();
  end
endmodule : tb_top
